//--- shared/jtp_pkg.sv
// jtp_pkg: states, instruction codes and widths for the test access port
// assumes: used by the tap controller and by the testbench tb_top
package jtp_pkg;
    // sixteen controller states
    typedef enum logic [3:0]
    {
        st_reset, st_idle, st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr,
        st_pause_dr, st_exit2_dr, st_upd_dr, st_sel_ir, st_cap_ir,
        st_shift_ir, st_exit1_ir, st_pause_ir, st_exit2_ir, st_upd_ir
    } jtp_state_e;
    localparam int IR_WIDTH = 3;                  // instruction length
    localparam logic [2:0] IR_CAPTURE = 3'h4;     // fixed capture pattern 100
    localparam logic [2:0] INS_EXTEST = 3'h0;     // boundary drive
    localparam logic [2:0] INS_SAMPLE = 3'h1;     // sample / preload
    localparam logic [2:0] INS_IDCODE = 3'h2;     // identification
    localparam logic [2:0] INS_BYPASS = 3'h7;     // one-stage bypass
    localparam int ID_WIDTH = 32;                 // identification width
    localparam logic [31:0] ID_VALUE = 32'h0000_1001; // arbitrary value
    localparam int SYNC_STAGES = 3;               // pin sampler depth
endpackage

//--- shared/jtp_pins_if.sv
// jtp_pins_if: cleaned test pin levels and edge pulses on the system clock
// assumes: filled by the sampler, read by the controller
`timescale 1ns/1ps
`default_nettype none
interface jtp_pins_if;
    logic tck_rise; // one-cycle pulse at rising test clock edge
    logic tck_fall; // one-cycle pulse at falling test clock edge
    logic tms;      // settled mode select
    logic tdi;      // settled serial input
    modport source (output tck_rise, tck_fall, tms, tdi);
    modport sink (input tck_rise, tck_fall, tms, tdi);
endinterface
`default_nettype wire

//--- logic/jtp_pin_sampler.sv
// jtp_pin_sampler: three-flop sampling of test pins, edge finding on tck
// assumes: pins are asynchronous to clock; a change counts when stages agree
`timescale 1ns/1ps
`default_nettype none
module jtp_pin_sampler
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    jtp_pins_if.source pins
);
    typedef struct packed
    {
        logic [2:0] s1;   // first stage, read only by second
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] lvl;  // accepted levels
        logic rise;
        logic fall;
    } jtp_smp_s;
    jtp_smp_s r;
    jtp_smp_s next_r;

    // a level is accepted once stages two and three agree
    always_comb
    begin
        next_r = r;
        next_r.s1 = {tck, tms, tdi};
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        for (int i = 0; i < 3; i++)
        begin
            if (r.s2[i] == r.s3[i])
            begin
                next_r.lvl[i] = r.s3[i];
            end
        end
        next_r.rise = next_r.lvl[2] & ~r.lvl[2];
        next_r.fall = ~next_r.lvl[2] & r.lvl[2];
    end

    // register stage, frozen while clock enable is low
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            r <= '0;
        end
        else if (clk_en)
        begin
            r <= next_r;
        end
    end

    assign pins.tck_rise = r.rise & clk_en;
    assign pins.tck_fall = r.fall & clk_en;
    assign pins.tms = r.lvl[1];
    assign pins.tdi = r.lvl[0];
endmodule // jtp_pin_sampler
`default_nettype wire

//--- logic/jtp_tap.sv
// jtp_tap: test access port controller with instruction, bypass,
// identification and boundary scan registers
// assumes: tester drives tck, tms, tdi; tck far slower than clock
//
// Summary of operation
// - sixteen states, advanced by tms on tck rise
// - reset state: test off, load identification instruction
// - five tms-high edges always reach reset
// - idle holds on tms low, else select-dr
// - select-dr: low captures, high to select-ir
// - capture-dr loads pins for extest or sample
// - capture-dr: high exit1, low shift
// - shift-dr moves selected register toward tdo
// - exit1-dr: high update, low pause
// - pause-dr holds; high goes to exit2
// - exit2-dr: high update, low shift
// - boundary latch updates on falling edge only
// - select-ir: low capture-ir, high reset
// - capture-ir loads fixed pattern 100
// - capture-ir: high exit1-ir, low shift-ir
`timescale 1ns/1ps
`default_nettype none
module jtp_tap
#(
    parameter int BSR_LEN = 8 // boundary scan cells
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic [BSR_LEN-1:0] pin_in,
    output logic tdo,
    output logic tdo_oe,
    output logic [BSR_LEN-1:0] bsr_out,
    output logic test_active
);
    // elaboration check: a one-cell chain is not supported, since
    // the boundary shift slice below would then run backwards
    if (BSR_LEN < 2)
    begin : g_bad_len
        $error("BSR_LEN must be at least two");
    end

    jtp_pins_if pins ();

    // pin cleanup and edge finding
    jtp_pin_sampler u_sampler
    (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .pins(pins)
    );

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed
    {
        jtp_pkg::jtp_state_e st;
        logic [jtp_pkg::IR_WIDTH-1:0] ir_sh;  // instruction shift path
        logic [jtp_pkg::IR_WIDTH-1:0] ir;     // current instruction
        logic bypass;
        logic [jtp_pkg::ID_WIDTH-1:0] id_sh;
        logic [BSR_LEN-1:0] bsr_sh;           // boundary shift path
        logic [BSR_LEN-1:0] bsr_lat;          // boundary parallel latch
        logic tdo;
        logic tdo_oe;
        logic active;
    } jtp_tap_s;
    jtp_tap_s r;
    jtp_tap_s next_r;

    logic bsr_sel; // boundary register on the serial path
    logic id_sel;  // identification register on the serial path
    logic ser_out; // bit presented toward tdo

    ////////////////////////////////////////////////////////////////////////
    // register selection from current instruction
    always_comb
    begin
        bsr_sel = (r.ir == jtp_pkg::INS_EXTEST) ||
                  (r.ir == jtp_pkg::INS_SAMPLE);
        id_sel = (r.ir == jtp_pkg::INS_IDCODE);
        if (r.st == jtp_pkg::st_shift_ir)
        begin
            ser_out = r.ir_sh[0];
        end
        else if (bsr_sel)
        begin
            ser_out = r.bsr_sh[0];
        end
        else if (id_sel)
        begin
            ser_out = r.id_sh[0];
        end
        else
        begin
            ser_out = r.bypass;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state walk and register actions
    always_comb
    begin
        next_r = r;
        if (pins.tck_rise)
        begin
            // actions of the state being left, on the rising edge
            unique case (r.st)
                jtp_pkg::st_cap_dr:
                begin
                    if (bsr_sel)
                    begin
                        next_r.bsr_sh = pin_in;
                    end
                    next_r.id_sh = jtp_pkg::ID_VALUE;
                    next_r.bypass = 1'b0;
                end
                jtp_pkg::st_shift_dr:
                begin
                    // only the selected register moves
                    if (bsr_sel)
                    begin
                        next_r.bsr_sh = {pins.tdi, r.bsr_sh[BSR_LEN-1:1]};
                    end
                    else if (id_sel)
                    begin
                        next_r.id_sh =
                            {pins.tdi, r.id_sh[jtp_pkg::ID_WIDTH-1:1]};
                    end
                    else
                    begin
                        next_r.bypass = pins.tdi;
                    end
                end
                jtp_pkg::st_cap_ir:
                begin
                    next_r.ir_sh = jtp_pkg::IR_CAPTURE;
                end
                jtp_pkg::st_shift_ir:
                begin
                    next_r.ir_sh =
                        {pins.tdi, r.ir_sh[jtp_pkg::IR_WIDTH-1:1]};
                end
                default:
                begin
                    // other states leave every register alone
                end
            endcase
            // next state from sampled tms
            unique case (r.st)
                jtp_pkg::st_reset:
                    next_r.st = pins.tms ? jtp_pkg::st_reset
                                         : jtp_pkg::st_idle;
                jtp_pkg::st_idle:
                    next_r.st = pins.tms ? jtp_pkg::st_sel_dr
                                         : jtp_pkg::st_idle;
                jtp_pkg::st_sel_dr:
                    next_r.st = pins.tms ? jtp_pkg::st_sel_ir
                                         : jtp_pkg::st_cap_dr;
                jtp_pkg::st_cap_dr:
                    next_r.st = pins.tms ? jtp_pkg::st_exit1_dr
                                         : jtp_pkg::st_shift_dr;
                jtp_pkg::st_shift_dr:
                    next_r.st = pins.tms ? jtp_pkg::st_exit1_dr
                                         : jtp_pkg::st_shift_dr;
                jtp_pkg::st_exit1_dr:
                    next_r.st = pins.tms ? jtp_pkg::st_upd_dr
                                         : jtp_pkg::st_pause_dr;
                jtp_pkg::st_pause_dr:
                    next_r.st = pins.tms ? jtp_pkg::st_exit2_dr
                                         : jtp_pkg::st_pause_dr;
                jtp_pkg::st_exit2_dr:
                    next_r.st = pins.tms ? jtp_pkg::st_upd_dr
                                         : jtp_pkg::st_shift_dr;
                jtp_pkg::st_upd_dr:
                    next_r.st = pins.tms ? jtp_pkg::st_sel_dr
                                         : jtp_pkg::st_idle;
                jtp_pkg::st_sel_ir:
                    next_r.st = pins.tms ? jtp_pkg::st_reset
                                         : jtp_pkg::st_cap_ir;
                jtp_pkg::st_cap_ir:
                    next_r.st = pins.tms ? jtp_pkg::st_exit1_ir
                                         : jtp_pkg::st_shift_ir;
                jtp_pkg::st_shift_ir:
                    next_r.st = pins.tms ? jtp_pkg::st_exit1_ir
                                         : jtp_pkg::st_shift_ir;
                jtp_pkg::st_exit1_ir:
                    next_r.st = pins.tms ? jtp_pkg::st_upd_ir
                                         : jtp_pkg::st_pause_ir;
                jtp_pkg::st_pause_ir:
                    next_r.st = pins.tms ? jtp_pkg::st_exit2_ir
                                         : jtp_pkg::st_pause_ir;
                jtp_pkg::st_exit2_ir:
                    next_r.st = pins.tms ? jtp_pkg::st_upd_ir
                                         : jtp_pkg::st_shift_ir;
                jtp_pkg::st_upd_ir:
                    next_r.st = pins.tms ? jtp_pkg::st_sel_dr
                                         : jtp_pkg::st_idle;
            endcase
        end
        if (pins.tck_fall)
        begin
            // update latches and serial output on the falling edge
            if (r.st == jtp_pkg::st_upd_dr && bsr_sel)
            begin
                next_r.bsr_lat = r.bsr_sh;
            end
            if (r.st == jtp_pkg::st_upd_ir)
            begin
                next_r.ir = r.ir_sh;
            end
            // driven only while a shift state is active
            next_r.tdo_oe = (r.st == jtp_pkg::st_shift_dr) ||
                            (r.st == jtp_pkg::st_shift_ir);
            next_r.tdo = ser_out;
        end
        // reset state keeps identification and test logic off
        if (r.st == jtp_pkg::st_reset)
        begin
            next_r.ir = jtp_pkg::INS_IDCODE;
        end
        next_r.active = (r.ir == jtp_pkg::INS_EXTEST) &&
                        (r.st != jtp_pkg::st_reset);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register, frozen while clock enable is low
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            r <= '{st: jtp_pkg::st_reset, ir: jtp_pkg::INS_IDCODE,
                   default: '0};
        end
        else if (clk_en)
        begin
            r <= next_r;
        end
    end

    assign tdo = r.tdo;
    assign tdo_oe = r.tdo_oe;
    assign bsr_out = r.bsr_lat;
    assign test_active = r.active;
endmodule // jtp_tap
`default_nettype wire

//--- verif/jtp_tap_properties.sv
// jtp_tap_chk: port timing checks of the test access port
// assumes: bound to jtp_tap; tck much slower than clock
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_chk
#(
    parameter int BSR_LEN = 8
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic [BSR_LEN-1:0] pin_in,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [BSR_LEN-1:0] bsr_out,
    input wire logic test_active
);
    logic tck_q; // last tck sample
    logic [3:0] since_rise; // clocks since tck rose, saturating
    logic [3:0] since_fall; // clocks since tck fell, saturating
    logic [2:0] hi_rises; // tms-high rises in a row, stops at 5
    ////////////////////////////////////////////////////////////
    // edge ages; outputs trail each edge by the sampler lag only
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            tck_q <= 1'b0;
            since_rise <= 4'hf;
            since_fall <= 4'hf;
            hi_rises <= 3'h0;
        end
        else
        begin
            tck_q <= tck;
            if (tck && !tck_q)
                since_rise <= 4'h0;
            else if (since_rise != 4'hf)
                since_rise <= since_rise + 4'h1;
            if (!tck && tck_q)
                since_fall <= 4'h0;
            else if (since_fall != 4'hf)
                since_fall <= since_fall + 4'h1;
            if (tck && !tck_q)
                hi_rises <= tms ? hi_rises + {2'h0, hi_rises != 3'h5} : 3'h0;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_quiet; !test_active && !tdo_oe; endsequence
    sequence s_near_fall; since_fall <= 4'h6; endsequence
    property p_tdo_fall; $changed(tdo) |-> s_near_fall; endproperty
    property p_oe_rise; $rose(tdo_oe) |-> s_near_fall; endproperty
    property p_oe_drop; $fell(tdo_oe) |-> s_near_fall; endproperty
    property p_latch_fall; $changed(bsr_out) |-> s_near_fall; endproperty
    property p_latch_shift; tdo_oe && $past(tdo_oe) |-> $stable(bsr_out);
    endproperty
    property p_act_edge;
        $changed(test_active) |-> (since_rise <= 4'h6) or s_near_fall;
    endproperty
    property p_five_high;
        hi_rises == 3'h5 && since_rise >= 4'h8 |-> s_quiet;
    endproperty
    property p_out_reset; $fell(rst) |-> s_quiet [*8]; endproperty
    a_tdo_fall: assert property (p_tdo_fall)
        else $error("tdo moved away from a tck fall");
    a_oe_rise: assert property (p_oe_rise)
        else $error("tdo_oe rose away from a tck fall");
    a_oe_drop: assert property (p_oe_drop)
        else $error("tdo_oe dropped away from a tck fall");
    a_latch_fall: assert property (p_latch_fall)
        else $error("bsr_out moved away from a tck fall");
    a_latch_shift: assert property (p_latch_shift)
        else $error("bsr_out moved while shifting");
    a_act_edge: assert property (p_act_edge)
        else $error("test_active moved without a tck edge");
    a_five_high: assert property (p_five_high)
        else $error("five tms-high rises left test logic on");
    a_out_reset: assert property (p_out_reset)
        else $error("outputs active just after reset");
endmodule // jtp_tap_chk
bind jtp_tap jtp_tap_chk #(.BSR_LEN(BSR_LEN)) chk_u (.clock(clock), .rst(rst),
    .clk_en(clk_en), .tck(tck), .tms(tms), .tdi(tdi), .pin_in(pin_in),
    .tdo(tdo), .tdo_oe(tdo_oe), .bsr_out(bsr_out),
    .test_active(test_active));
`default_nettype wire

//--- verif/jtp_tester.sv
// jtp_tester: boundary scan tester driving tck, tms and tdi
// assumes: clock is the bench clock; tdo line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module jtp_tester
(
    input wire logic clock,
    input wire logic tdo,
    input wire logic tdo_oe,
    output logic tck,
    output logic tms,
    output logic tdi
);
    wire logic line = tdo_oe ? tdo : 1'b1; // released tdo floats high
    ////////////////////////////////////////////////////////////
    // tck idles low; 7 clocks low and 6 high, with tms set 6 clocks before rise, keeps tms settled at rise
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one tck period: tms/tdi set one clock into the low half, tdo taken at the rise
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge clock);
        tms <= m;
        tdi <= d;
        repeat (6) @(posedge clock);
        o = line;
        tck <= 1'b1;
        repeat (6) @(posedge clock);
        tck <= 1'b0;
    endtask
endmodule // jtp_tester
`default_nettype wire

//--- verif/tb_top.sv
// tb_top: random and corner scans of the test access port
// assumes: jtp_tester makes tck; BSR_LEN kept at 8
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock, rst, clk_en, tck, tms, tdi, tdo, tdo_oe, test_active, o;
    logic [7:0] pin_in, bsr_out, lat, pin, want;
    logic [31:0] seed, din, dout;
    logic [2:0] ins;
    int err_count, compares;
    jtp_tap #(.BSR_LEN(8)) dut_u (.clock(clock), .rst(rst), .clk_en(clk_en),
        .tck(tck), .tms(tms), .tdi(tdi), .pin_in(pin_in), .tdo(tdo),
        .tdo_oe(tdo_oe), .bsr_out(bsr_out), .test_active(test_active));
    jtp_tester tester_u (.clock(clock), .tdo(tdo), .tdo_oe(tdo_oe),
        .tck(tck), .tms(tms), .tdi(tdi));
    ////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // boundary instructions return the pins; bypass delays tdi one stage
    function automatic logic [7:0] exp_dr(input logic [2:0] i,
        input logic [7:0] p, input logic [7:0] d);
        return (i == jtp_pkg::INS_BYPASS) ? {d[6:0], 1'b0} : p;
    endfunction
    // only extest turns the test logic on
    function automatic logic act(input logic [2:0] i);
        return i === jtp_pkg::INS_EXTEST;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            err_count++;
        end
    endtask
    task automatic results;
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic go(input logic m);
        tester_u.step(m, 1'b0, o);
    endtask
    // scan from idle; bit p detours through pause and back
    task automatic scan(input logic ir, input int n, input int p,
        input logic [31:0] d, output logic [31:0] q);
        q = '0;
        go(1'b1);
        if (ir)
            go(1'b1);
        go(1'b0);
        go(1'b0);
        for (int i = 0; i < n; i++)
        begin
            tester_u.step(i == n - 1 || i == p, d[i], q[i]);
            if (i == p && i != n - 1)
            begin
                go(1'b0);
                go(1'b0);
                check(32'(tdo_oe), 32'h0);
                check(32'(bsr_out), 32'(lat));
                go(1'b1);
                go(1'b0);
            end
        end
        go(1'b1);
        go(1'b0);
    endtask
    // watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (100000) @(posedge clock);
        err_count++;
        results();
    end
    initial
    begin
        rst = 1'b1;
        clk_en = 1'b1;
        pin_in = 8'h00;
        lat = 8'h00;
        seed = 32'h0001_4cfd;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        repeat (6) @(posedge clock);
        check(32'(test_active), 32'h0);
        for (int k = 0; k < 6; k++)
        begin
            seed = xs(seed);
            go(seed[0]);
        end
        repeat (5) go(1'b1);
        go(1'b0);
        go(1'b0);
        scan(1'b0, 32, 40, seed, dout);
        check(dout, jtp_pkg::ID_VALUE);
        check(32'(bsr_out), 32'(lat));
        // extest last, so the closing reset walk must switch test logic off
        for (int j = 0; j < 3; j++)
        begin
            ins = j == 2 ? jtp_pkg::INS_EXTEST :
                  j == 1 ? jtp_pkg::INS_BYPASS : jtp_pkg::INS_SAMPLE;
            scan(1'b1, 3, 9, 32'(ins), dout);
            check(32'(dout[2:0]), 32'(jtp_pkg::IR_CAPTURE));
            check(32'(test_active), 32'(act(ins)));
            seed = xs(seed);
            pin = seed[7:0];
            pin_in <= pin;
            din = xs(seed);
            seed = din;
            scan(1'b0, 8, 3, din, dout);
            want = exp_dr(ins, pin, din[7:0]);
            check(32'(dout[7:0]), 32'(want));
            if (ins != jtp_pkg::INS_BYPASS)
            begin
                lat = din[7:0]; // only a selected boundary register latches
            end
            check(32'(bsr_out), 32'(lat));
        end
        repeat (4) go(1'b1);
        check(32'(test_active), 32'h0);
        check(32'(bsr_out), 32'(lat));
        results();
    end
endmodule // tb_top
`default_nettype wire
